/* include/pphv_pkg.sv */
// package for the parallel high-voltage programming port
// assumes a single 20 MHz clock domain; no bus, all control is plain ports
package pphv_pkg;

	// ------------------------------------------------------------
	// port action selector and commands
	// ------------------------------------------------------------
	localparam logic [1:0] PPHV_ACT_ADDR = 2'h0;
	localparam logic [1:0] PPHV_ACT_DATA = 2'h1;
	localparam logic [1:0] PPHV_ACT_CMD  = 2'h2;
	localparam logic [1:0] PPHV_ACT_IDLE = 2'h3;

	localparam logic [7:0] PPHV_CMD_NOP     = 8'h00;
	localparam logic [7:0] PPHV_CMD_ERASE   = 8'h80;
	localparam logic [7:0] PPHV_CMD_WFUSE   = 8'h40;
	localparam logic [7:0] PPHV_CMD_WLOCK   = 8'h20;
	localparam logic [7:0] PPHV_CMD_WFLASH  = 8'h10;
	localparam logic [7:0] PPHV_CMD_WEE     = 8'h11;
	localparam logic [7:0] PPHV_CMD_RSIG    = 8'h08;
	localparam logic [7:0] PPHV_CMD_RFUSE   = 8'h04;
	localparam logic [7:0] PPHV_CMD_RFLASH  = 8'h02;
	localparam logic [7:0] PPHV_CMD_REE     = 8'h03;

	// ------------------------------------------------------------
	// reset values and timing
	// ------------------------------------------------------------
	localparam logic [7:0] PPHV_FUSE_LO_RST = 8'hff;
	localparam logic [7:0] PPHV_FUSE_HI_RST = 8'hff;
	localparam logic [7:0] PPHV_FUSE_EX_RST = 8'hff;
	localparam logic [7:0] PPHV_LOCK_RST    = 8'hff;
	// lock bit positions: two basic lock bits, boot lock bits above them
	localparam int PPHV_LOCK_ONE_POS  = 0;
	localparam int PPHV_LOCK_TWO_POS  = 1;
	localparam logic [7:0] PPHV_BOOT_LOCK_MASK = 8'h3c;
	localparam int PPHV_CLK_MHZ    = 20;
	localparam int PPHV_PROG_US    = 100;
	localparam int PPHV_PROG_CYC   = PPHV_PROG_US * PPHV_CLK_MHZ;
	localparam int PPHV_CNT_W      = 16;

endpackage

/* include/pphv_sync_if.sv */
// interface carrying the synchronised strobes from the pin stage to the core
// assumes both ends run on i_mclk
`timescale 1ns/1ps
interface pphv_sync_if;
	logic       load_rise;
	logic       latch_rise;
	logic       wr_fall;
	logic       oe_n;
	logic [1:0] act;
	logic       bsa;
	logic       bsb;
	logic [7:0] bus;
	modport src (output load_rise, output latch_rise, output wr_fall, output oe_n,
		output act, output bsa, output bsb, output bus);
	modport dst (input load_rise, input latch_rise, input wr_fall, input oe_n,
		input act, input bsa, input bsb, input bus);
endinterface

/* core/pphv_pin_sync.sv */
// pin stage: two-flop synchronisers and edge detection for the programmer pins
// assumes pins are asynchronous to i_mclk and strobes last several clocks
`timescale 1ns/1ps
module pphv_pin_sync (
	input  wire logic       i_mclk,
	input  wire logic       i_rst_n,
	input  wire logic       i_ce,
	input  wire logic [15:0] i_pins,
	pphv_sync_if.src        sy
);
	// pins: [7:0] bus, 8 load, 9 latch, 10 wr_n, 11 oe_n, 12 sel_lo, 13 sel_hi, 14 bsa, 15 bsb
	logic [15:0] s1_q, s1_d, s2_q, s2_d, s3_q, s3_d;

	always_comb begin
		s1_d = i_ce ? i_pins : s1_q;
		s2_d = i_ce ? s1_q : s2_q;
		s3_d = i_ce ? s2_q : s3_q;
	end

	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			s1_q <= 16'h0c00;
			s2_q <= 16'h0c00;
			s3_q <= 16'h0c00;
		end else begin
			s1_q <= s1_d;
			s2_q <= s2_d;
			s3_q <= s3_d;
		end
	end

	assign sy.bus        = s2_q[7:0];
	assign sy.load_rise  = i_ce & s2_q[8] & ~s3_q[8];
	assign sy.latch_rise = i_ce & s2_q[9] & ~s3_q[9];
	assign sy.wr_fall    = i_ce & ~s2_q[10] & s3_q[10];
	assign sy.oe_n       = s2_q[11];
	assign sy.act        = {s2_q[13], s2_q[12]};
	assign sy.bsa        = s2_q[14];
	assign sy.bsb        = s2_q[15];
endmodule // pphv_pin_sync

/* core/pphv_port.sv */
// parallel high-voltage programming port: command/address/data loading,
// page buffers, memory writes, fuse and lock handling, read-back
// assumes the programmer strobes are slow against i_mclk (pulses >= 250 ns)
`timescale 1ns/1ps
module pphv_port
	import pphv_pkg::*;
#(
	parameter int FLASH_AW   = 13,
	parameter int FLASH_WW   = 6,
	parameter int EE_AW      = 9,
	parameter int EE_WW      = 2,
	parameter int PROG_CYC   = PPHV_PROG_CYC,
	parameter logic [7:0] SIG0 = 8'h1e,  // arbitrary
	parameter logic [7:0] SIG1 = 8'h55,  // arbitrary
	parameter logic [7:0] SIG2 = 8'h0a,  // arbitrary
	parameter logic [7:0] CAL  = 8'h80   // arbitrary
) (
	input  wire logic       i_mclk,
	input  wire logic       i_rst_n,
	input  wire logic       i_ce,
	input  wire logic       i_load_strobe,
	input  wire logic       i_page_latch_strobe,
	input  wire logic       i_wr_n,
	input  wire logic       i_oe_n,
	input  wire logic       i_action_sel_lo,
	input  wire logic       i_action_sel_hi,
	input  wire logic       i_byte_sel_a,
	input  wire logic       i_byte_sel_b,
	input  wire logic [7:0] i_data,
	output logic      [7:0] o_data,
	output logic            o_data_oe,
	output logic            o_ready_busy_n,
	output logic      [7:0] o_fuse_lo,
	output logic      [7:0] o_fuse_hi,
	output logic      [7:0] o_fuse_ex,
	output logic      [7:0] o_lock
);
	localparam int FW = 1 << FLASH_WW;
	localparam int EW = 1 << EE_WW;
	localparam int FN = 1 << FLASH_AW;
	localparam int EN = 1 << EE_AW;

	pphv_sync_if sy ();

	pphv_pin_sync u_sync (
		.i_mclk  (i_mclk),
		.i_rst_n (i_rst_n),
		.i_ce    (i_ce),
		.i_pins  ({i_byte_sel_b, i_byte_sel_a, i_action_sel_hi, i_action_sel_lo, i_oe_n,
			i_wr_n, i_page_latch_strobe, i_load_strobe, i_data}),
		.sy      (sy)
	);

	// ------------------------------------------------------------
	// storage
	// ------------------------------------------------------------
	logic [15:0] flash_mem [FN];
	logic [7:0]  ee_mem    [EN];
	logic [15:0] fbuf      [FW];
	logic [7:0]  ebuf      [EW];
	logic [FW-1:0] fbuf_v;
	logic [EW-1:0] ebuf_v;

	typedef enum {PPHV_IDLE, PPHV_BUSY} pphv_state_e;

	logic [7:0]  cmd_q, cmd_d;
	logic [15:0] addr_q, addr_d;
	logic [15:0] wdat_q, wdat_d;
	logic [7:0]  fuse_lo_q, fuse_lo_d, fuse_hi_q, fuse_hi_d, fuse_ex_q, fuse_ex_d;
	logic [7:0]  lock_q, lock_d;
	logic        wen_q, wen_d;
	pphv_state_e st_q, st_d;
	logic [PPHV_CNT_W-1:0] cnt_q, cnt_d;
	logic        commit_flash, commit_ee, erase_all;

	// ------------------------------------------------------------
	// loading and write control
	// ------------------------------------------------------------
	logic        ld_cmd, wr_go;
	logic [7:0]  lock_new;
	always_comb begin
		cmd_d     = cmd_q;
		addr_d    = addr_q;
		wdat_d    = wdat_q;
		fuse_lo_d = fuse_lo_q;
		fuse_hi_d = fuse_hi_q;
		fuse_ex_d = fuse_ex_q;
		lock_d    = lock_q;
		wen_d     = wen_q;
		st_d      = st_q;
		cnt_d     = cnt_q;
		commit_flash = 1'b0;
		commit_ee    = 1'b0;
		erase_all    = 1'b0;
		ld_cmd    = 1'b0;
		wr_go     = sy.wr_fall && st_q == PPHV_IDLE && wen_q;
		lock_new  = lock_q & wdat_q[7:0];
		if (!(lock_q[PPHV_LOCK_ONE_POS] | lock_q[PPHV_LOCK_TWO_POS]))
			lock_new = (lock_new & ~PPHV_BOOT_LOCK_MASK) | (lock_q & PPHV_BOOT_LOCK_MASK);
		if (sy.load_rise && st_q == PPHV_IDLE) begin
			case (sy.act)
				PPHV_ACT_ADDR: begin
					if (sy.bsa)
						addr_d[15:8] = sy.bus;
					else
						addr_d[7:0] = sy.bus;
				end
				PPHV_ACT_DATA: begin
					if (sy.bsa)
						wdat_d[15:8] = sy.bus;
					else
						wdat_d[7:0] = sy.bus;
				end
				PPHV_ACT_CMD: begin
					cmd_d  = sy.bus;
					ld_cmd = 1'b1;
					wen_d  = (sy.bus != PPHV_CMD_NOP);
				end
				PPHV_ACT_IDLE: ;
				default: ;
			endcase
		end
		case (st_q)
			PPHV_IDLE: begin
				if (wr_go) begin
					case (cmd_q)
						PPHV_CMD_WFLASH: commit_flash = 1'b1;
						PPHV_CMD_WEE: commit_ee = !sy.bsa;
						PPHV_CMD_WFUSE: begin
							case ({sy.bsb, sy.bsa})
								2'h0: fuse_lo_d = wdat_q[7:0];
								2'h1: fuse_hi_d = wdat_q[7:0];
								2'h2: fuse_ex_d = wdat_q[7:0];
								default: ;
							endcase
						end
						PPHV_CMD_WLOCK: lock_d = lock_new;
						PPHV_CMD_ERASE: begin
							erase_all = 1'b1;
							lock_d = PPHV_LOCK_RST;
						end
						default: ;
					endcase
					st_d  = PPHV_BUSY;
					cnt_d = PPHV_CNT_W'(PROG_CYC - 1);
				end
			end
			PPHV_BUSY: begin
				if (i_ce) begin
					if (cnt_q == '0)
						st_d = PPHV_IDLE;
					else
						cnt_d = cnt_q - 1'b1;
				end
			end
			default: st_d = PPHV_IDLE;
		endcase
	end

	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			cmd_q     <= PPHV_CMD_NOP;
			addr_q    <= 16'h0000;
			wdat_q    <= 16'hffff;
			fuse_lo_q <= PPHV_FUSE_LO_RST;
			fuse_hi_q <= PPHV_FUSE_HI_RST;
			fuse_ex_q <= PPHV_FUSE_EX_RST;
			lock_q    <= PPHV_LOCK_RST;
			wen_q     <= 1'b0;
			st_q      <= PPHV_IDLE;
			cnt_q     <= '0;
		end else begin
			cmd_q     <= cmd_d;
			addr_q    <= addr_d;
			wdat_q    <= wdat_d;
			fuse_lo_q <= fuse_lo_d;
			fuse_hi_q <= fuse_hi_d;
			fuse_ex_q <= fuse_ex_d;
			lock_q    <= lock_d;
			wen_q     <= wen_d;
			st_q      <= st_d;
			cnt_q     <= cnt_d;
		end
	end

	// ------------------------------------------------------------
	// page buffers and memory arrays
	// ------------------------------------------------------------
	// buffers are written on the latch strobe; memories only at commit, so the
	// arrays carry no reset and may map to ram
	logic [FLASH_WW-1:0] fword;
	logic [EE_WW-1:0]    eword;
	logic [FLASH_AW-FLASH_WW-1:0] fpage;
	logic [EE_AW-EE_WW-1:0]       epage;
	assign fword = addr_q[FLASH_WW-1:0];
	assign fpage = addr_q[FLASH_AW-1:FLASH_WW];
	assign eword = addr_q[EE_WW-1:0];
	assign epage = addr_q[EE_AW-1:EE_WW];

	logic latch_go;
	assign latch_go = sy.latch_rise && sy.bsa && st_q == PPHV_IDLE;

	// any command load empties both buffers, so stale bytes of an earlier session
	// are never committed by a later write; a latch in the same cycle still wins
	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			fbuf_v <= '0;
			ebuf_v <= '0;
		end else begin
			if (commit_flash || ld_cmd)
				fbuf_v <= '0;
			if (latch_go && cmd_q == PPHV_CMD_WFLASH)
				fbuf_v[fword] <= 1'b1;
			if (commit_ee || ld_cmd)
				ebuf_v <= '0;
			if (latch_go && cmd_q == PPHV_CMD_WEE)
				ebuf_v[eword] <= 1'b1;
		end
	end

	always_ff @(posedge i_mclk) begin
		if (latch_go && cmd_q == PPHV_CMD_WFLASH)
			fbuf[fword] <= wdat_q;
		if (latch_go && cmd_q == PPHV_CMD_WEE)
			ebuf[eword] <= wdat_q[7:0];
		for (int i = 0; i < FW; i++) begin
			if (commit_flash && fbuf_v[i])
				flash_mem[{fpage, FLASH_WW'(i)}] <= fbuf[i];
		end
		for (int j = 0; j < EW; j++) begin
			if (commit_ee && ebuf_v[j])
				ee_mem[{epage, EE_WW'(j)}] <= ebuf[j];
		end
	end

	// ------------------------------------------------------------
	// read-back path
	// ------------------------------------------------------------
	logic [7:0] rd_d, rd_q;
	logic       oe_d, oe_q;
	always_comb begin
		rd_d = 8'hff;
		oe_d = !sy.oe_n;
		case (cmd_q)
			PPHV_CMD_RFLASH: begin
				rd_d = sy.bsa ? flash_mem[addr_q[FLASH_AW-1:0]][15:8]
					: flash_mem[addr_q[FLASH_AW-1:0]][7:0];
			end
			PPHV_CMD_REE: rd_d = ee_mem[addr_q[EE_AW-1:0]];
			PPHV_CMD_RFUSE: begin
				case ({sy.bsb, sy.bsa})
					2'h0: rd_d = fuse_lo_q;
					2'h3: rd_d = fuse_hi_q;
					2'h2: rd_d = fuse_ex_q;
					default: rd_d = lock_q;
				endcase
			end
			PPHV_CMD_RSIG: begin
				if (sy.bsa)
					rd_d = (addr_q[7:0] == 8'h00) ? CAL : 8'hff;
				else if (addr_q[7:0] == 8'h00)
					rd_d = SIG0;
				else if (addr_q[7:0] == 8'h01)
					rd_d = SIG1;
				else if (addr_q[7:0] == 8'h02)
					rd_d = SIG2;
				else
					rd_d = 8'hff;
			end
			default: rd_d = 8'hff;
		endcase
	end

	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			rd_q <= 8'hff;
			oe_q <= 1'b0;
		end else if (i_ce) begin
			rd_q <= rd_d;
			oe_q <= oe_d;
		end
	end

	assign o_data         = rd_q;
	assign o_data_oe      = oe_q;
	assign o_ready_busy_n = (st_q == PPHV_IDLE);
	assign o_fuse_lo      = fuse_lo_q;
	assign o_fuse_hi      = fuse_hi_q;
	assign o_fuse_ex      = fuse_ex_q;
	assign o_lock         = lock_q;

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	property p_busy_on_write;
		@(posedge i_mclk) disable iff (!i_rst_n) wr_go |=> !o_ready_busy_n;
	endproperty
	a_busy_on_write: assert property (p_busy_on_write) else $error("no busy after write");

	property p_busy_holds;
		@(posedge i_mclk) disable iff (!i_rst_n)
			$fell(o_ready_busy_n) && i_ce |=> !o_ready_busy_n;
	endproperty
	a_busy_holds: assert property (p_busy_holds) else $error("busy too short");

	property p_oe_follow;
		@(posedge i_mclk) disable iff (!i_rst_n) i_ce |=> o_data_oe == !$past(sy.oe_n);
	endproperty
	a_oe_follow: assert property (p_oe_follow) else $error("bus drive mismatch");

	property p_addr_lo;
		@(posedge i_mclk) disable iff (!i_rst_n)
			sy.load_rise && st_q == PPHV_IDLE && sy.act == PPHV_ACT_ADDR && !sy.bsa
			|=> addr_q[7:0] == $past(sy.bus);
	endproperty
	a_addr_lo: assert property (p_addr_lo) else $error("address low not loaded");

	property p_addr_hi;
		@(posedge i_mclk) disable iff (!i_rst_n)
			sy.load_rise && st_q == PPHV_IDLE && sy.act == PPHV_ACT_ADDR && sy.bsa
			|=> addr_q[15:8] == $past(sy.bus);
	endproperty
	a_addr_hi: assert property (p_addr_hi) else $error("address high not loaded");

	property p_nop_clears;
		@(posedge i_mclk) disable iff (!i_rst_n)
			ld_cmd && sy.bus == PPHV_CMD_NOP |=> !wen_q;
	endproperty
	a_nop_clears: assert property (p_nop_clears) else $error("write not cleared");

	property p_lock_monotone;
		@(posedge i_mclk) disable iff (!i_rst_n)
			!erase_all |=> (lock_q & ~$past(lock_q)) == 8'h00;
	endproperty
	a_lock_monotone: assert property (p_lock_monotone) else $error("lock bit cleared");

	property p_idle_act;
		@(posedge i_mclk) disable iff (!i_rst_n)
			sy.load_rise && sy.act == PPHV_ACT_IDLE |=> $stable(cmd_q) && $stable(addr_q);
	endproperty
	a_idle_act: assert property (p_idle_act) else $error("idle action changed state");

	c_flash_write: cover property (@(posedge i_mclk) commit_flash);
	c_ee_write: cover property (@(posedge i_mclk) commit_ee);
	c_fuse_read: cover property (@(posedge i_mclk) o_data_oe && cmd_q == PPHV_CMD_RFUSE);
endmodule // pphv_port

/* dv/pphv_prog_model.sv */
// programmer model: drives the port pins and the shared data bus
// assumes the device samples its pins on i_mclk and answers on its data outputs
`timescale 1ns/1ps
module pphv_prog_model (
	input  wire logic       i_mclk,
	input  wire logic       i_ready_busy_n,
	input  wire logic [7:0] i_dev_data,
	input  wire logic       i_dev_oe,
	output logic            o_load_strobe,
	output logic            o_page_latch_strobe,
	output logic            o_wr_n,
	output logic            o_oe_n,
	output logic [1:0]      o_act,
	output logic            o_bsa,
	output logic            o_bsb,
	output wire logic [7:0] o_bus
);
	logic       drv_en;
	logic [7:0] drv_val;

	// a released bus shows the inverse, so a stale value never reads as good
	assign o_bus = i_dev_oe ? i_dev_data : (drv_en ? drv_val : ~drv_val);
	initial begin
		o_load_strobe = 1'b0;
		o_page_latch_strobe = 1'b0;
		o_wr_n = 1'b1;
		o_oe_n = 1'b1;
		o_act = 2'h3;
		o_bsa = 1'b0;
		o_bsb = 1'b0;
		drv_en = 1'b0;
		drv_val = 8'h00;
	end

	task automatic hold(input int n);
		repeat (n) @(negedge i_mclk);
	endtask

	// pins are held six cycles, above the five the port needs
	task automatic ld(input logic [1:0] a, input logic s, input logic [7:0] d);
		o_act = a;
		o_bsa = s;
		drv_val = d;
		drv_en = 1'b1;
		hold(6);
		o_load_strobe = 1'b1;
		hold(6);
		o_load_strobe = 1'b0;
		hold(6);
	endtask

	task automatic latch;
		o_bsa = 1'b1;
		hold(6);
		o_page_latch_strobe = 1'b1;
		hold(6);
		o_page_latch_strobe = 1'b0;
		hold(6);
	endtask

	// returns the number of cycles seen busy; selectors go back low after ready
	task automatic wr(input logic s, input logic b, output int cnt);
		o_bsa = s;
		o_bsb = b;
		hold(6);
		o_wr_n = 1'b0;
		cnt = 0;
		repeat (6) begin
			hold(1);
			if (i_ready_busy_n === 1'b0) cnt++;
		end
		o_wr_n = 1'b1;
		for (int g = 0; g < 1000 && cnt > 0 && i_ready_busy_n !== 1'b1; g++) begin
			hold(1);
			if (i_ready_busy_n === 1'b0) cnt++;
		end
		o_bsa = 1'b0;
		o_bsb = 1'b0;
		hold(6);
	endtask

	task automatic rd(input logic s, input logic b, output logic [7:0] d);
		drv_en = 1'b0;
		o_bsa = s;
		o_bsb = b;
		o_oe_n = 1'b0;
		hold(8);
		d = o_bus;
		o_oe_n = 1'b1;
		hold(8);
	endtask
endmodule // pphv_prog_model

/* dv/tb_top.sv */
// testbench: sequences of programmer operations with expected values
// assumes pphv_port and the programmer model share one 20 MHz clock
`timescale 1ns/1ps
module tb_top;
	import pphv_pkg::*;
	localparam int P = 20;
	logic       mclk = 1'b0;
	logic       rst_n = 1'b0;
	logic       ce = 1'b1;
	logic       ld_s, lt_s, wr_n, oe_n, bsa, bsb, doe, rdy;
	logic [1:0] act;
	logic [7:0] dout, flo, fhi, fex, lck;
	wire  [7:0] bus;
	int         n_mismatch = 0;
	int         num_checks = 0;
	int         cyc = 0;
	logic [7:0] sig [3] = '{8'h31, 8'h42, 8'h53};
	logic [7:0] fv [3] = '{8'he2, 8'hd9, 8'hf9};

	always #25 mclk = ~mclk;

	pphv_port #(.PROG_CYC(P), .SIG0(8'h31), .SIG1(8'h42), .SIG2(8'h53), .CAL(8'h64)) u_dut (
		.i_mclk(mclk), .i_rst_n(rst_n), .i_ce(ce), .i_load_strobe(ld_s),
		.i_page_latch_strobe(lt_s), .i_wr_n(wr_n), .i_oe_n(oe_n),
		.i_action_sel_lo(act[0]), .i_action_sel_hi(act[1]), .i_byte_sel_a(bsa),
		.i_byte_sel_b(bsb), .i_data(bus), .o_data(dout), .o_data_oe(doe),
		.o_ready_busy_n(rdy), .o_fuse_lo(flo), .o_fuse_hi(fhi), .o_fuse_ex(fex),
		.o_lock(lck));

	pphv_prog_model u_prog (
		.i_mclk(mclk), .i_ready_busy_n(rdy), .i_dev_data(dout), .i_dev_oe(doe),
		.o_load_strobe(ld_s), .o_page_latch_strobe(lt_s), .o_wr_n(wr_n),
		.o_oe_n(oe_n), .o_act(act), .o_bsa(bsa), .o_bsb(bsb), .o_bus(bus));

	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		num_checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("FAIL %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic busy(input string nm, input logic s, input logic b);
		int c;
		u_prog.wr(s, b, c);
		chk(nm, 8'h01, {7'h00, (c >= P - 1 && c <= P + 1)});
	endtask

	task automatic rdchk(input string nm, input logic s, input logic b, input logic [7:0] e);
		logic [7:0] d;
		u_prog.rd(s, b, d);
		chk(nm, e, d);
	endtask

	task automatic wrap_up;
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// the whole sequence needs about 1400 cycles
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 20000) begin
			n_mismatch++;
			wrap_up();
		end
	end

	initial begin
		int c;
		repeat (5) @(negedge mclk);
		rst_n = 1'b1;
		u_prog.hold(3);
		chk("ready", 8'h01, {7'h00, rdy});
		chk("lock", 8'hff, lck);
		chk("fuse_lo", 8'hff, flo);
		$display("test reset done");
		// two words in page 5 of the flash, word index 5 and 6
		u_prog.ld(PPHV_ACT_CMD, 1'b0, PPHV_CMD_WFLASH);
		u_prog.ld(PPHV_ACT_ADDR, 1'b0, 8'h45);
		u_prog.ld(PPHV_ACT_DATA, 1'b0, 8'ha5);
		u_prog.ld(PPHV_ACT_DATA, 1'b1, 8'h3c);
		u_prog.latch();
		u_prog.ld(PPHV_ACT_ADDR, 1'b0, 8'h46);
		u_prog.ld(PPHV_ACT_DATA, 1'b0, 8'h0f);
		u_prog.ld(PPHV_ACT_DATA, 1'b1, 8'hf0);
		u_prog.latch();
		u_prog.ld(PPHV_ACT_ADDR, 1'b1, 8'h01);
		busy("flash busy", 1'b0, 1'b0);
		u_prog.ld(PPHV_ACT_CMD, 1'b0, PPHV_CMD_RFLASH);
		u_prog.ld(PPHV_ACT_ADDR, 1'b1, 8'h01);
		u_prog.ld(PPHV_ACT_ADDR, 1'b0, 8'h45);
		rdchk("flash lo", 1'b0, 1'b0, 8'ha5);
		rdchk("flash hi", 1'b1, 1'b0, 8'h3c);
		u_prog.ld(PPHV_ACT_IDLE, 1'b0, 8'h46);
		rdchk("idle load", 1'b0, 1'b0, 8'ha5);
		u_prog.ld(PPHV_ACT_ADDR, 1'b0, 8'h46);
		rdchk("flash lo 2", 1'b0, 1'b0, 8'h0f);
		rdchk("flash hi 2", 1'b1, 1'b0, 8'hf0);
		chk("bus released", 8'h00, {7'h00, doe});
		u_prog.ld(PPHV_ACT_CMD, 1'b0, PPHV_CMD_NOP);
		u_prog.wr(1'b0, 1'b0, c);
		chk("nop write", 8'h00, c[7:0]);
		$display("test flash done");
		u_prog.ld(PPHV_ACT_CMD, 1'b0, PPHV_CMD_WEE);
		u_prog.ld(PPHV_ACT_ADDR, 1'b1, 8'h01);
		u_prog.ld(PPHV_ACT_ADDR, 1'b0, 8'h06);
		u_prog.ld(PPHV_ACT_DATA, 1'b0, 8'h5a);
		u_prog.latch();
		u_prog.ld(PPHV_ACT_ADDR, 1'b0, 8'h07);
		u_prog.ld(PPHV_ACT_DATA, 1'b0, 8'hc3);
		u_prog.latch();
		busy("ee busy", 1'b0, 1'b0);
		u_prog.ld(PPHV_ACT_CMD, 1'b0, PPHV_CMD_REE);
		u_prog.ld(PPHV_ACT_ADDR, 1'b1, 8'h01);
		u_prog.ld(PPHV_ACT_ADDR, 1'b0, 8'h06);
		rdchk("ee 6", 1'b0, 1'b0, 8'h5a);
		u_prog.ld(PPHV_ACT_ADDR, 1'b0, 8'h07);
		rdchk("ee 7", 1'b0, 1'b0, 8'hc3);
		$display("test eeprom done");
		for (int i = 0; i < 3; i++) begin
			u_prog.ld(PPHV_ACT_CMD, 1'b0, PPHV_CMD_WFUSE);
			u_prog.ld(PPHV_ACT_DATA, 1'b0, fv[i]);
			busy("fuse busy", i == 1, i == 2);
		end
		chk("fuse_lo", fv[0], flo);
		chk("fuse_hi", fv[1], fhi);
		chk("fuse_ex", fv[2], fex);
		u_prog.ld(PPHV_ACT_CMD, 1'b0, PPHV_CMD_RFUSE);
		rdchk("rd fuse_lo", 1'b0, 1'b0, fv[0]);
		rdchk("rd fuse_hi", 1'b1, 1'b1, fv[1]);
		rdchk("rd fuse_ex", 1'b0, 1'b1, fv[2]);
		rdchk("rd lock", 1'b1, 1'b0, 8'hff);
		$display("test fuse done");
		u_prog.ld(PPHV_ACT_CMD, 1'b0, PPHV_CMD_WLOCK);
		u_prog.ld(PPHV_ACT_DATA, 1'b0, 8'hfc);
		busy("lock busy", 1'b0, 1'b0);
		chk("lock mode3", 8'hfc, lck);
		u_prog.ld(PPHV_ACT_DATA, 1'b0, 8'hc3);
		busy("lock busy", 1'b0, 1'b0);
		chk("boot lock", 8'hfc, lck);
		u_prog.ld(PPHV_ACT_CMD, 1'b0, PPHV_CMD_RFUSE);
		rdchk("rd lock", 1'b1, 1'b0, 8'hfc);
		u_prog.ld(PPHV_ACT_CMD, 1'b0, PPHV_CMD_ERASE);
		busy("erase busy", 1'b0, 1'b0);
		chk("lock erased", 8'hff, lck);
		$display("test lock done");
		u_prog.ld(PPHV_ACT_CMD, 1'b0, PPHV_CMD_RSIG);
		for (int i = 0; i < 3; i++) begin
			u_prog.ld(PPHV_ACT_ADDR, 1'b0, i[7:0]);
			rdchk("signature", 1'b0, 1'b0, sig[i]);
		end
		u_prog.ld(PPHV_ACT_ADDR, 1'b0, 8'h00);
		rdchk("calibration", 1'b1, 1'b0, 8'h64);
		// a whole load pulse while the clock enable is low must leave no trace
		ce = 1'b0;
		u_prog.ld(PPHV_ACT_ADDR, 1'b0, 8'h02);
		ce = 1'b1;
		rdchk("ce freeze", 1'b0, 1'b0, sig[0]);
		$display("test signature done");
		wrap_up();
	end
endmodule // tb_top
